// >>> hw/ufs_params.svh
// Offsets, field positions, reset values and timing counts of the fault status block.
`ifndef UFS_PARAMS_SVH
`define UFS_PARAMS_SVH

`define UFS_CFS_OFFSET 12'hD28
`define UFS_ILLEGAL_STATE_BIT 17
`define UFS_UNKNOWN_OPCODE_BIT 16
`define UFS_LOC_VALID_BIT 15
`define UFS_RSVD_HI 14
`define UFS_RSVD_LO 13
`define UFS_CFS_RESET 32'h0000_0000
`define UFS_PC_RESET 32'h0000_0000
`define UFS_CLK_PERIOD_NS 4
`define UFS_WAIT_STATES 0

`endif

// >>> hw/ufs_pkg.sv
// Types and shared decode functions of the fault status block.
`default_nettype none
`include "ufs_params.svh"

package ufs_pkg;

    typedef enum logic [0:0] {
        UFS_IDLE = 1'b0,
        UFS_ACCESS = 1'b1
    } ufs_apb_state_t;

    typedef struct packed {
        ufs_apb_state_t state;
        logic pready;
        logic pslverr;
    } ufs_apb_regs_t;

    typedef struct packed {
        logic illegal_state_use_fault;
        logic unknown_opcode_fault;
        logic bus_error_location_valid;
        logic [31:0] stacked_pc;
        logic [31:0] prdata;
    } ufs_top_regs_t;

    // Word-address match against the configurable fault status register.
    function automatic logic ufs_hit(input logic [11:0] addr);
        logic [11:0] base;
        base = `UFS_CFS_OFFSET;
        return addr[11:2] == base[11:2];
    endfunction

    // Expands byte strobes to a bit mask.
    function automatic logic [31:0] ufs_lane_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return m;
    endfunction

endpackage

`default_nettype wire

// >>> hw/ufs_reg_if.sv
// Register access strobes passed from the bus slave to the status register.
`timescale 1ns/100ps
`default_nettype none

interface ufs_reg_if;
    logic setup;
    logic wr_en;
    logic [31:0] wdata;
    logic [3:0] strb;

    modport slave (output setup, output wr_en, output wdata, output strb);
    modport regs (input setup, input wr_en, input wdata, input strb);
endinterface

`default_nettype wire

// >>> hw/ufs_apb_slave.sv
// APB slave front end: zero-wait-state access with error on unmapped address.
`timescale 1ns/100ps
`default_nettype none

module ufs_apb_slave (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic pslverr,
    ufs_reg_if.slave bus
);
    import ufs_pkg::*;

    ufs_apb_regs_t r;
    ufs_apb_regs_t next_r;

    always_comb begin
        next_r = r;
        case (r.state)
            UFS_IDLE: begin
                next_r.pready = 1'b0;
                next_r.pslverr = 1'b0;
                if (psel && !penable) begin
                    next_r.state = UFS_ACCESS;
                    next_r.pready = 1'b1;
                    next_r.pslverr = !ufs_hit(paddr);
                end
            end
            UFS_ACCESS: begin
                next_r.state = UFS_IDLE;
                next_r.pready = 1'b0;
                next_r.pslverr = 1'b0;
            end
            default: begin
                next_r.state = UFS_IDLE;
                next_r.pready = 1'b0;
                next_r.pslverr = 1'b0;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{state: UFS_IDLE, pready: 1'b0, pslverr: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    assign pready = r.pready;
    assign pslverr = r.pslverr;
    assign bus.setup = (r.state == UFS_IDLE) && psel && !penable;
    assign bus.wr_en = (r.state == UFS_ACCESS) && psel && penable && pwrite && !r.pslverr;
    assign bus.wdata = pwdata;
    assign bus.strb = pstrb;
endmodule

`default_nettype wire

// >>> hw/ufs_fault_capture.sv
// Qualifies core fault events and forms the set and clear requests.
`timescale 1ns/100ps
`default_nettype none

module ufs_fault_capture (
    input wire logic fault_valid,
    input wire logic decode_fail,
    input wire logic illegal_state_use,
    input wire logic bus_fault,
    input wire logic bus_fault_addr_known,
    input wire logic other_fault,
    output logic set_illegal_state,
    output logic set_unknown_opcode,
    output logic set_loc_valid,
    output logic clr_loc_valid,
    output logic capture_pc
);
    assign set_illegal_state = fault_valid && illegal_state_use && !decode_fail;
    assign set_unknown_opcode = fault_valid && decode_fail;
    assign set_loc_valid = fault_valid && bus_fault && bus_fault_addr_known;
    assign clr_loc_valid = fault_valid && other_fault;
    assign capture_pc = set_illegal_state || set_unknown_opcode;
endmodule

`default_nettype wire

// >>> hw/ufs_fault_status.sv
// Usage and bus fault status bits of the configurable fault status register.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ufs_params.svh"

module ufs_fault_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fault_valid,
    input wire logic [31:0] fault_pc,
    input wire logic decode_fail,
    input wire logic illegal_state_use,
    input wire logic bus_fault,
    input wire logic bus_fault_addr_known,
    input wire logic other_fault,
    output logic [31:0] stacked_return_pc,
    output logic illegal_state_use_fault,
    output logic unknown_opcode_fault,
    output logic bus_error_location_valid
);
    import ufs_pkg::*;

    ufs_reg_if bus ();

    ufs_top_regs_t r;
    ufs_top_regs_t next_r;
    logic set_illegal_state;
    logic set_unknown_opcode;
    logic set_loc_valid;
    logic clr_loc_valid;
    logic capture_pc;

    ufs_apb_slave u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .pstrb(pstrb),
        .pready(pready),
        .pslverr(pslverr),
        .bus(bus.slave)
    );

    ufs_fault_capture u_cap (
        .fault_valid(fault_valid),
        .decode_fail(decode_fail),
        .illegal_state_use(illegal_state_use),
        .bus_fault(bus_fault),
        .bus_fault_addr_known(bus_fault_addr_known),
        .other_fault(other_fault),
        .set_illegal_state(set_illegal_state),
        .set_unknown_opcode(set_unknown_opcode),
        .set_loc_valid(set_loc_valid),
        .clr_loc_valid(clr_loc_valid),
        .capture_pc(capture_pc)
    );

    // Builds the register image; the reserved field and unimplemented bits read zero.
    function automatic logic [31:0] image(input ufs_top_regs_t s);
        logic [31:0] w;
        w = `UFS_CFS_RESET;
        w[`UFS_ILLEGAL_STATE_BIT] = s.illegal_state_use_fault;
        w[`UFS_UNKNOWN_OPCODE_BIT] = s.unknown_opcode_fault;
        w[`UFS_LOC_VALID_BIT] = s.bus_error_location_valid;
        w[`UFS_RSVD_HI:`UFS_RSVD_LO] = 2'h0;
        return w;
    endfunction

    logic [31:0] clr_mask;

    always_comb begin
        clr_mask = bus.wr_en ? (bus.wdata & ufs_lane_mask(bus.strb)) : 32'h0000_0000;
        next_r = r;
        next_r.illegal_state_use_fault = set_illegal_state
            || (r.illegal_state_use_fault && !clr_mask[`UFS_ILLEGAL_STATE_BIT]);
        next_r.unknown_opcode_fault = set_unknown_opcode
            || (r.unknown_opcode_fault && !clr_mask[`UFS_UNKNOWN_OPCODE_BIT]);
        next_r.bus_error_location_valid = set_loc_valid
            || (r.bus_error_location_valid && !clr_mask[`UFS_LOC_VALID_BIT] && !clr_loc_valid);
        if (capture_pc) begin
            next_r.stacked_pc = fault_pc;
        end
        if (bus.setup) begin
            next_r.prdata = ufs_hit(paddr) ? image(r) : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '{1'b0, 1'b0, 1'b0, `UFS_PC_RESET, 32'h0000_0000};
        end else begin
            r <= next_r;
        end
    end

    assign prdata = r.prdata;
    assign stacked_return_pc = r.stacked_pc;
    assign illegal_state_use_fault = r.illegal_state_use_fault;
    assign unknown_opcode_fault = r.unknown_opcode_fault;
    assign bus_error_location_valid = r.bus_error_location_valid;
endmodule

`default_nettype wire

// >>> verif/ufs_properties.sv
// Concurrent checks on the fault status block ports.
`timescale 1ns/100ps
`default_nettype none
module ufs_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fault_valid,
    input wire logic [31:0] fault_pc,
    input wire logic decode_fail,
    input wire logic illegal_state_use,
    input wire logic bus_fault,
    input wire logic bus_fault_addr_known,
    input wire logic other_fault,
    input wire logic [31:0] stacked_return_pc,
    input wire logic illegal_state_use_fault,
    input wire logic unknown_opcode_fault,
    input wire logic bus_error_location_valid
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ill_set_a: assert property (
        fault_valid && illegal_state_use && !decode_fail |=> illegal_state_use_fault)
        else $error("bit17 not set");
    pc_saved_a: assert property (
        fault_valid && (decode_fail || illegal_state_use)
        |=> stacked_return_pc == $past(fault_pc)) else $error("stacked pc wrong");
    opcode_only_a: assert property (
        fault_valid && decode_fail && !illegal_state_use_fault |=> !illegal_state_use_fault)
        else $error("bit17 set by undefined");
    opcode_set_a: assert property (
        fault_valid && decode_fail |=> unknown_opcode_fault) else $error("bit16 not set");
    loc_set_a: assert property (
        fault_valid && bus_fault && bus_fault_addr_known |=> bus_error_location_valid)
        else $error("bit15 not set");
    loc_clear_a: assert property (
        fault_valid && other_fault && !bus_fault |=> !bus_error_location_valid)
        else $error("bit15 not cleared");
    w1c_only_a: assert property (
        $fell(unknown_opcode_fault) |-> $past(psel && penable && pwrite && pstrb[2] && pwdata[16]))
        else $error("bit16 fell without write");
    read_image_a: assert property (
        psel && !penable && !pwrite && paddr[11:2] == 10'h34A |=> pready
        && prdata[17:13] == {$past(illegal_state_use_fault), $past(unknown_opcode_fault),
        $past(bus_error_location_valid), 2'h0}) else $error("read image wrong");
    unmapped_a: assert property (
        psel && !penable && paddr[11:2] != 10'h34A |=> pready && pslverr)
        else $error("no error on unmapped");
    cover property (fault_valid && illegal_state_use);
    cover property ($fell(bus_error_location_valid));
    cover property (pslverr);
    cover property (fault_valid && bus_fault && bus_fault_addr_known && psel && penable && pwrite);
endmodule
`default_nettype wire

// >>> verif/ufs_core_model.sv
// Core-side fault event source for the fault status block.
`timescale 1ns/100ps
`default_nettype none
module ufs_core_model (
    input wire logic pclk,
    output logic fault_valid,
    output logic [31:0] fault_pc,
    output logic [4:0] kind
);
    initial begin
        fault_valid = 1'b0;
        fault_pc = 32'h0;
        kind = 5'h0;
    end
    task automatic fire(input logic [4:0] k, input logic [31:0] pc);
        @(posedge pclk);
        fault_valid <= 1'b1;
        kind <= k;
        fault_pc <= pc;
        @(posedge pclk);
        fault_valid <= 1'b0;
        kind <= ~k;
        fault_pc <= ~pc;
    endtask
endmodule
`default_nettype wire

// >>> verif/ufs_fault_status_tb_top.sv
// Testbench top for the fault status block.
`timescale 1ns/100ps
`default_nettype none
module ufs_fault_status_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, spc, fpc;
    logic [3:0] pstrb;
    logic [4:0] kind;
    logic [2:0] flags;
    int failures = 0;
    int checks_done = 0;
    ufs_core_model core_u (.pclk, .fault_valid(fv), .fault_pc(fpc), .kind);
    ufs_fault_status dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .fault_valid(fv), .fault_pc(fpc),
        .decode_fail(kind[4]), .illegal_state_use(kind[3]), .bus_fault(kind[2]),
        .bus_fault_addr_known(kind[1]), .other_fault(kind[0]), .stacked_return_pc(spc),
        .illegal_state_use_fault(flags[2]), .unknown_opcode_fault(flags[1]),
        .bus_error_location_valid(flags[0]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic [3:0] s, input logic [31:0] e, input logic er);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (w === 1'b0) chk(prdata, e);
        chk({31'h0, pslverr}, {31'h0, er});
        @(posedge pclk);
    endtask
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, 12'hD28, 0, 4'hF, 0, 0);
        core_u.fire(5'h08, 32'h0000_1234);
        xfer(0, 12'hD28, 0, 4'hF, 32'h0002_0000, 0);
        chk(spc, 32'h0000_1234);
        chk({29'h0, flags}, 32'h0000_0004);
        xfer(1, 12'hD28, 32'h0, 4'hF, 0, 0);
        xfer(1, 12'hD28, 32'hFFFF_FFFF, 4'hB, 0, 0);
        xfer(0, 12'hD28, 0, 4'hF, 32'h0002_0000, 0);
        xfer(1, 12'hD2A, 32'h0002_0000, 4'h4, 0, 0);
        $display("test 1 done");
        core_u.fire(5'h18, 32'h0000_2000);
        xfer(0, 12'hD28, 0, 4'hF, 32'h0001_0000, 0);
        chk(spc, 32'h0000_2000);
        core_u.fire(5'h06, 32'h0);
        xfer(0, 12'hD28, 0, 4'hF, 32'h0001_8000, 0);
        chk({29'h0, flags}, 32'h0000_0003);
        core_u.fire(5'h01, 32'h0);
        xfer(0, 12'hD28, 0, 4'hF, 32'h0001_0000, 0);
        fork
            core_u.fire(5'h07, 32'h0);
            xfer(1, 12'hD29, 32'h0000_8000, 4'h2, 0, 0);
        join
        xfer(0, 12'hD28, 0, 4'hF, 32'h0001_8000, 0);
        $display("test 2 done");
        core_u.fire(5'h06, 32'h0);
        xfer(1, 12'hD29, 32'h0000_8000, 4'h2, 0, 0);
        xfer(1, 12'hD28, 32'hFFFF_FFFF, 4'hF, 0, 0);
        core_u.fire(5'h04, 32'h0);
        xfer(0, 12'hD28, 0, 4'hF, 0, 0);
        chk({29'h0, flags}, 32'h0000_0000);
        xfer(0, 12'hD2C, 0, 4'hF, 0, 1);
        $display("test 3 done");
        core_u.fire(5'h10, 32'h0000_3000);
        @(posedge pclk);
        chk({29'h0, flags}, 32'h0000_0002);
        chk(spc, 32'h0000_3000);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, 12'hD28, 0, 4'hF, 0, 0);
        chk(spc, 32'h0000_0000);
        chk({29'h0, flags}, 32'h0000_0000);
        $display("test 4 done");
        end_of_test();
    end
endmodule
bind ufs_fault_status ufs_properties prop_u (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .fault_valid, .fault_pc,
    .decode_fail, .illegal_state_use, .bus_fault, .bus_fault_addr_known, .other_fault,
    .stacked_return_pc, .illegal_state_use_fault, .unknown_opcode_fault,
    .bus_error_location_valid);
`default_nettype wire
